// ==== rtl/lsd_ctrl.v ====
// Purpose: segment LCD drive controller, 40 segments x 4 commons
// Assumes: clk is the fast system clock; slow_tick is a one-cycle
//   enable from the slow clock, on clk; stop_mode from same domain
// Notes: line outputs are 2-bit level codes for the analog driver
`timescale 1ns/1ps
`include "lsd_map.vh"

// Operation
// - boost select picks one of four rates
// - booster off takes bias from pins
// - buffer of 20 bytes at fc0 to fd3
// - hardware scans buffer continuously into waveforms
// - bit one lights pixel, zero dark
// - nibble bits map to commons by duty
// - unused buffer bits are plain storage
// - byte low nibble even segment, high odd
// - enable bit zero blanks the panel
// - blanked lines all driven to ground
// - stop mode clears enable; software resets
// - reset: commons low, shared segments floating
// - boost code table for both clocks
// - four drive methods selectable
// - frame rate from base clock by duty
module lsd_ctrl #(
  parameter NSEG = 40,
  parameter NCOM = 4,
  parameter FDIV = 17
) (
  input wire clk,
  input wire nrst,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  input wire stop_mode,
  input wire slow_clk_sel,
  input wire slow_tick,
  output reg boost_tick_q,
  output reg bias_from_pins_q,
  output reg [2*NCOM-1:0] com_level_q,
  output reg [2*NSEG-1:0] seg_level_q,
  output reg [NSEG-1:0] seg_oe_q
);

  localparam NB = NSEG / 2;
  localparam NSC = NSEG / 8;

  // Reset release is synchronised; assertion stays asynchronous
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_n = rst_s_q;

  // Mask of the low k bits, used for every divider tap
  function [FDIV-1:0] low_mask;
    input [4:0] k;
    integer i;
    begin
      low_mask = {FDIV{1'b0}};
      for (i = 0; i < FDIV; i = i + 1) begin
        if (i < k) begin
          low_mask[i] = 1'b1;
        end
      end
    end
  endfunction

  // Tap fires once per 2^k counts of its counter
  function tap_hit;
    input [FDIV-1:0] cnt;
    input [4:0] k;
    begin
      tap_hit = ((cnt & low_mask(k)) == low_mask(k));
    end
  endfunction

  // Level of a selected common for the frame polarity
  function [1:0] sel_level;
    input pol;
    begin
      sel_level = pol ? `LSD_LV_GND : `LSD_LV_HIGH;
    end
  endfunction

  // Control and segment output control registers
  reg [7:0] ctrl_q;
  reg [7:0] segctl_q [0:NSC-1];
  // Display buffer, every bit readable and writable
  reg [7:0] buf_q [0:NB-1];
  reg stop_q;

  wire en_bit = ctrl_q[`LSD_F_EN];
  wire boost_en = ctrl_q[`LSD_F_BOOST];
  wire [1:0] duty = ctrl_q[`LSD_F_DUTY_HI:`LSD_F_DUTY_LO];
  wire [1:0] boost_clock_select = ctrl_q[`LSD_F_VF_HI:`LSD_F_VF_LO];
  wire [1:0] frame_rate_select = ctrl_q[`LSD_F_FRM_HI:`LSD_F_FRM_LO];

  wire in_buf = (addr >= `LSD_BUF_BASE) && (addr <= `LSD_BUF_LAST);
  wire in_seg = (addr >= `LSD_SEGCTL_BASE) && (addr <= `LSD_SEGCTL_LAST);
  wire [11:0] buf_off = addr - `LSD_BUF_BASE;
  wire [11:0] seg_off = addr - `LSD_SEGCTL_BASE;
  wire stop_rise = stop_mode && !stop_q;

  // Control register; stop entry beats a same-cycle enable write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `LSD_CTRL_RST;
      stop_q <= 1'b0;
    end else if (!rst_n) begin
      ctrl_q <= `LSD_CTRL_RST;
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode;
      if (wr_stb && addr == `LSD_CTRL_ADDR) begin
        ctrl_q <= wdata;
      end
      if (stop_rise) begin
        ctrl_q[`LSD_F_EN] <= 1'b0;
      end
    end
  end

  // Segment output control bytes, one bit per segment pin
  integer s;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (s = 0; s < NSC; s = s + 1) begin
        segctl_q[s] <= `LSD_SEGCTL_RST;
      end
    end else if (wr_stb && in_seg && rst_n) begin
      segctl_q[seg_off[2:0]] <= wdata;
    end
  end

  // Buffer has no reset: contents are undefined at power-up,
  // so software must fill it before enabling the display.
  // buffer window
  always @(posedge clk) begin
    if (wr_stb && in_buf) begin
      buf_q[buf_off[4:0]] <= wdata;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `LSD_CTRL_ADDR) begin
        rdata_q <= ctrl_q;
      end else if (in_seg) begin
        rdata_q <= segctl_q[seg_off[2:0]];
      end else if (in_buf) begin
        rdata_q <= buf_q[buf_off[4:0]];
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Free-running prescalers on the fast clock and the slow tick
  reg [FDIV-1:0] fdiv_q;
  reg [FDIV-1:0] sdiv_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fdiv_q <= {FDIV{1'b0}};
      sdiv_q <= {FDIV{1'b0}};
    end else begin
      fdiv_q <= fdiv_q + 1'b1;
      if (slow_tick) begin
        sdiv_q <= sdiv_q + 1'b1;
      end
    end
  end

  // Booster rate; code 11 stays on the fast clock in slow mode
  reg [4:0] bst_k;
  reg bst_slow;
  always @* begin
    bst_slow = slow_clk_sel && (boost_clock_select != 2'h3);
    case (boost_clock_select)
      2'h0: bst_k = bst_slow ? `LSD_BST_S0 : `LSD_BST_F0;
      2'h1: bst_k = bst_slow ? `LSD_BST_S1 : `LSD_BST_F1;
      2'h2: bst_k = bst_slow ? `LSD_BST_S2 : `LSD_BST_F2;
      default: bst_k = `LSD_BST_F3;
    endcase
  end
  wire bst_hit = bst_slow ? (slow_tick && tap_hit(sdiv_q, bst_k))
                          : tap_hit(fdiv_q, bst_k);

  // Frame base; codes 10 and 11 only exist on the fast clock
  reg [4:0] frm_k;
  reg frm_slow;
  always @* begin
    frm_slow = slow_clk_sel && !frame_rate_select[1];
    case (frame_rate_select)
      2'h0: frm_k = frm_slow ? `LSD_FRM_S0 : `LSD_FRM_F0;
      2'h1: frm_k = frm_slow ? `LSD_FRM_S1 : `LSD_FRM_F1;
      2'h2: frm_k = `LSD_FRM_F2;
      default: frm_k = `LSD_FRM_F3;
    endcase
  end
  // Four slots per base period give the base rate at 1/4 duty
  wire [4:0] slot_k = frm_k - `LSD_SLOT_SHIFT;
  wire slot_hit = frm_slow ? (slow_tick && tap_hit(sdiv_q, slot_k))
                           : tap_hit(fdiv_q, slot_k);

  // Booster pulse and bias source; no pulses while bias is external
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boost_tick_q <= 1'b0;
      bias_from_pins_q <= 1'b1;
    end else begin
      boost_tick_q <= boost_en && bst_hit && rst_n;
      bias_from_pins_q <= !boost_en;
    end
  end

  // Scan phase and polarity; fewer phases shorten the frame
  reg [1:0] phase_q;
  reg pol_q;
  reg [1:0] last_ph;
  always @* begin
    case (duty)
      `LSD_DUTY_4: last_ph = 2'h3;
      `LSD_DUTY_3: last_ph = 2'h2;
      `LSD_DUTY_2: last_ph = 2'h1;
      default: last_ph = 2'h3;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (!rst_n) begin
      phase_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (slot_hit) begin
      if (phase_q >= last_ph) begin
        phase_q <= 2'h0;
        pol_q <= !pol_q;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  // Static drives common 0 through the whole frame
  wire [1:0] com_sel = (duty == `LSD_DUTY_S) ? 2'h0 : phase_q;
  wire half_bias = (duty == `LSD_DUTY_2) || (duty == `LSD_DUTY_S);

  // Common levels: selected swings full, others sit at bias
  reg [2*NCOM-1:0] com_d;
  integer c;
  always @* begin
    com_d = {2*NCOM{1'b0}};
    for (c = 0; c < NCOM; c = c + 1) begin
      if (c == com_sel) begin
        com_d[2*c +: 2] = sel_level(pol_q);
      end else if (half_bias) begin
        com_d[2*c +: 2] = `LSD_LV_MID;
      end else begin
        com_d[2*c +: 2] = pol_q ? `LSD_LV_MID : `LSD_LV_LOW;
      end
    end
  end

  // Segment levels from the buffer bit of the selected common
  reg [2*NSEG-1:0] seg_d;
  reg [3:0] nib;
  reg pix;
  integer g;
  always @* begin
    seg_d = {2*NSEG{1'b0}};
    nib = 4'h0;
    pix = 1'b0;
    for (g = 0; g < NSEG; g = g + 1) begin
      nib = g[0] ? buf_q[g/2][7:4] : buf_q[g/2][3:0];
      pix = nib[com_sel];
      if (pix) begin
        seg_d[2*g +: 2] = sel_level(!pol_q);
      end else if (half_bias) begin
        seg_d[2*g +: 2] = sel_level(pol_q);
      end else begin
        seg_d[2*g +: 2] = pol_q ? `LSD_LV_LOW : `LSD_LV_MID;
      end
    end
  end

  // Output stage: blank to ground, reset holds commons low
  integer p;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      com_level_q <= {2*NCOM{1'b0}};
      seg_level_q <= {2*NSEG{1'b0}};
      seg_oe_q <= {NSEG{1'b0}};
    end else if (!rst_n) begin
      com_level_q <= {2*NCOM{1'b0}};
      seg_level_q <= {2*NSEG{1'b0}};
      seg_oe_q <= {NSEG{1'b0}};
    end else begin
      for (p = 0; p < NSEG; p = p + 1) begin
        seg_oe_q[p] <= segctl_q[p/8][p%8];
      end
      if (!en_bit) begin
        com_level_q <= {2*NCOM{1'b0}};
        seg_level_q <= {2*NSEG{1'b0}};
      end else begin
        com_level_q <= com_d;
        seg_level_q <= seg_d;
      end
    end
  end

endmodule // lsd_ctrl

// ==== rtl/lsd_map.vh ====
// Purpose: constants for the segment LCD controller
// Assumes: 12-bit byte address, 8-bit data
// Notes: level codes name the four drive voltages
`ifndef LSD_MAP_VH
`define LSD_MAP_VH

// Register and buffer addresses
`define LSD_CTRL_ADDR 12'h028
`define LSD_SEGCTL_BASE 12'h030
`define LSD_SEGCTL_LAST 12'h034
`define LSD_BUF_BASE 12'hfc0
`define LSD_BUF_LAST 12'hfd3
`define LSD_BUF_BYTES 20

// Control register fields
`define LSD_F_EN 7
`define LSD_F_BOOST 6
`define LSD_F_DUTY_HI 5
`define LSD_F_DUTY_LO 4
`define LSD_F_VF_HI 3
`define LSD_F_VF_LO 2
`define LSD_F_FRM_HI 1
`define LSD_F_FRM_LO 0
`define LSD_CTRL_RST 8'h00
`define LSD_SEGCTL_RST 8'h00

// Drive methods
`define LSD_DUTY_4 2'h0
`define LSD_DUTY_3 2'h1
`define LSD_DUTY_2 2'h2
`define LSD_DUTY_S 2'h3

// Output level codes: ground, bias low, mid, high
`define LSD_LV_GND 2'h0
`define LSD_LV_LOW 2'h1
`define LSD_LV_MID 2'h2
`define LSD_LV_HIGH 2'h3

// Divider exponents, fast clock (F) and slow clock (S)
`define LSD_BST_F0 5'd13
`define LSD_BST_F1 5'd11
`define LSD_BST_F2 5'd10
`define LSD_BST_F3 5'd9
`define LSD_BST_S0 5'd5
`define LSD_BST_S1 5'd3
`define LSD_BST_S2 5'd2
`define LSD_FRM_F0 5'd17
`define LSD_FRM_F1 5'd16
`define LSD_FRM_F2 5'd15
`define LSD_FRM_F3 5'd13
`define LSD_FRM_S0 5'd9
`define LSD_FRM_S1 5'd8
// Four scan slots per base period
`define LSD_SLOT_SHIFT 5'd2

`endif

// ==== testbench/lsd_ctrl_sva.sv ====
// Purpose: port checks for lsd_ctrl
// Assumes: boost period checked on the fast clock only
// Notes: shadows control and pin enable bytes
`timescale 1ns/1ps
`include "lsd_map.vh"
module lsd_ctrl_sva #(
  parameter NSEG = 40,
  parameter NCOM = 4,
  parameter FDIV = 17
) (
  input wire clk,
  input wire nrst,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata_q,
  input wire stop_mode,
  input wire slow_clk_sel,
  input wire slow_tick,
  input wire boost_tick_q,
  input wire bias_from_pins_q,
  input wire [2*NCOM-1:0] com_level_q,
  input wire [2*NSEG-1:0] seg_level_q,
  input wire [NSEG-1:0] seg_oe_q
);
  reg [7:0] ctl_q;
  reg [39:0] oe_q;
  reg [13:0] gap_q;
  reg ok_q;
  wire wctl = wr_stb && addr == `LSD_CTRL_ADDR;
  wire [3:0] bexp = (ctl_q[3:2] == 2'h0) ? 4'd13 : 4'd12 - ctl_q[3:2];
  wire [13:0] per = 14'h1 << bexp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Software view; a gap counts only if no control write fell inside it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= 8'h00;
      oe_q <= 40'h0;
      gap_q <= 14'h0;
      ok_q <= 1'b0;
    end else begin
      if (wctl)
        ctl_q <= wdata;
      // Stop entry beats a same-cycle write of the enable bit
      if ($rose(stop_mode))
        ctl_q[7] <= 1'b0;
      if (wr_stb && addr >= `LSD_SEGCTL_BASE && addr <= `LSD_SEGCTL_LAST)
        oe_q[{addr[2:0], 3'h0} +: 8] <= wdata;
      gap_q <= boost_tick_q ? 14'h0 : gap_q + 14'h1;
      ok_q <= (boost_tick_q | ok_q) & ~wctl & ~slow_clk_sel;
    end
  end
  sequence rd_ctl_s;
    rd_stb && addr == `LSD_CTRL_ADDR;
  endsequence
  sequence dark_s;
    com_level_q == 8'h00 && seg_level_q == 80'h0;
  endsequence
  rd_idle_a: assert property (rdata_q != 8'h00 |-> $past(rd_stb))
    else $error("read data outside slot");
  rd_unmap_a: assert property (rd_stb && addr == 12'hfd4 |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  rd_ctl_a: assert property (rd_ctl_s |=> rdata_q == $past(ctl_q))
    else $error("control readback wrong");
  blank_dark_a: assert property (!ctl_q[7] |=> dark_s)
    else $error("lines not dark while blanked");
  stop_dark_a: assert property ($rose(stop_mode) |-> ##[1:2] dark_s)
    else $error("stop did not blank");
  bias_src_a: assert property ($changed(ctl_q[6]) |-> ##[0:2] bias_from_pins_q == !ctl_q[6])
    else $error("bias source wrong");
  boost_off_a: assert property (!ctl_q[6] && !$past(ctl_q[6]) |-> !boost_tick_q)
    else $error("boost tick while off");
  boost_gap_a: assert property (boost_tick_q && ok_q && !slow_clk_sel |-> gap_q == per - 14'h1)
    else $error("boost period wrong");
  pin_oe_a: assert property ($changed(oe_q) |-> ##[0:2] seg_oe_q == oe_q)
    else $error("pin enable wrong");
endmodule // lsd_ctrl_sva
bind lsd_ctrl lsd_ctrl_sva #(.NSEG(NSEG), .NCOM(NCOM), .FDIV(FDIV)) u_sva (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_q(rdata_q), .stop_mode(stop_mode),
  .slow_clk_sel(slow_clk_sel), .slow_tick(slow_tick), .boost_tick_q(boost_tick_q),
  .bias_from_pins_q(bias_from_pins_q), .com_level_q(com_level_q),
  .seg_level_q(seg_level_q), .seg_oe_q(seg_oe_q));

// ==== testbench/lsd_panel.sv ====
// Purpose: glass model, reports lit pixels
// Assumes: level 0 ground, 3 top bias
// Notes: a pixel lights only under full swing
`timescale 1ns/1ps
module lsd_panel (
  input wire [7:0] com_level,
  input wire [79:0] seg_level,
  output reg [3:0] sel,
  output reg [39:0] lit
);
  integer c;
  integer s;
  always @* begin
    lit = 40'h0;
    for (c = 0; c < 4; c = c + 1) begin
      sel[c] = com_level[2*c +: 2] == 2'h3 || com_level[2*c +: 2] == 2'h0;
      for (s = 0; s < 40; s = s + 1)
        if (sel[c] && seg_level[2*s +: 2] == ~com_level[2*c +: 2])
          lit[s] = 1'b1;
    end
  end
endmodule // lsd_panel

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for lsd_ctrl
// Assumes: slow tick stand-in is one pulse per four clocks
// Notes: glass model turns levels into pixels
`timescale 1ns/1ps
`include "lsd_map.vh"
module tb_top;
  reg clk = 0;
  reg nrst = 0;
  reg [11:0] addr = 12'h000;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 0;
  reg rd_stb = 0;
  reg stop_mode = 0;
  reg slow_clk_sel = 0;
  reg slow_tick = 0;
  reg [1:0] tdiv = 2'h0;
  wire [7:0] rdata_q;
  wire boost_tick_q;
  wire bias_from_pins_q;
  wire [7:0] com_level_q;
  wire [79:0] seg_level_q;
  wire [39:0] seg_oe_q;
  wire [3:0] sel;
  wire [39:0] lit;
  integer err_total = 0;
  integer tests_run = 0;
  integer i;
  integer j;
  reg [7:0] d;
  initial forever #20 clk = ~clk;
  // Slow clock stand-in: one tick every four fast clocks in slow mode
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    slow_tick <= slow_clk_sel && tdiv == 2'h3;
  end
  lsd_ctrl dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_q(rdata_q), .stop_mode(stop_mode), .slow_clk_sel(slow_clk_sel),
    .slow_tick(slow_tick), .boost_tick_q(boost_tick_q), .bias_from_pins_q(bias_from_pins_q),
    .com_level_q(com_level_q), .seg_level_q(seg_level_q), .seg_oe_q(seg_oe_q));
  lsd_panel glass (.com_level(com_level_q), .seg_level(seg_level_q), .sel(sel), .lit(lit));
  task chk(input [79:0] s, input [79:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] v);
    begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [11:0] a);
    begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rdata_q;
    end
  endtask
  // Bounded waits; running out ends the run
  task wto;
    begin
      if (i >= 9000) begin
        chk(1, 0);
        finish_test;
      end
    end
  endtask
  task wsel(input [3:0] s);
    begin
      i = 0;
      while (sel !== s && i < 9000) begin
        @(negedge clk);
        i = i + 1;
      end
      wto;
    end
  endtask
  task wtick;
    begin
      @(negedge clk);
      i = 1;
      while (boost_tick_q !== 1'b1 && i < 9000) begin
        @(negedge clk);
        i = i + 1;
      end
      wto;
    end
  endtask
  task t_reset;
    begin
      @(negedge clk);
      chk(com_level_q, 0);
      chk(seg_oe_q, 0);
      chk(bias_from_pins_q, 1);
    end
  endtask
  task t_buf;
    begin
      // whole buffer written before any enable
      for (j = 0; j < 20; j = j + 1)
        wr(`LSD_BUF_BASE + j, j * 13 + 7);
      for (j = 0; j < 20; j = j + 1) begin
        rd(`LSD_BUF_BASE + j);
        chk(d, j * 13 + 7);
      end
      rd(12'hfd4);
      chk(d, 0);
    end
  endtask
  task t_pix;
    begin
      wr(`LSD_BUF_BASE, 8'h21);
      wr(`LSD_CTRL_ADDR, 8'h83);
      wsel(4'h1);
      chk(lit[1:0], 2'b01);
      wsel(4'h2);
      chk(lit[1:0], 2'b10);
      wsel(4'h8);
      chk(lit[1:0], 2'b00);
      wr(`LSD_BUF_BASE, 8'h12);
      wsel(4'h1);
      chk(lit[1:0], 2'b10);
    end
  endtask
  task t_stop;
    begin
      @(posedge clk);
      stop_mode <= 1'b1;
      repeat (3) @(negedge clk);
      chk({com_level_q, seg_level_q}, 0);
      rd(`LSD_CTRL_ADDR);
      chk(d, 8'h03);
      @(posedge clk);
      stop_mode <= 1'b0;
      wr(`LSD_BUF_BASE, 8'h06);
      wr(`LSD_CTRL_ADDR, 8'ha3);
      wsel(4'h2);
      chk(lit[0], 1);
      wsel(4'h1);
      chk(lit[0], 0);
    end
  endtask
  task t_blank;
    begin
      wr(`LSD_SEGCTL_BASE + 4, 8'ha5);
      wr(`LSD_CTRL_ADDR, 8'h03);
      repeat (3) @(negedge clk);
      chk({com_level_q, seg_level_q}, 0);
      chk(seg_oe_q[39:32], 8'ha5);
    end
  endtask
  // Static drive: common 0 stays selected across slots
  task t_static;
    begin
      wr(`LSD_BUF_BASE, 8'h1e);
      wr(`LSD_CTRL_ADDR, 8'hb3);
      repeat (3) @(negedge clk);
      chk(sel, 4'h1);
      chk(lit[1:0], 2'b10);
      repeat (3000) @(negedge clk);
      chk(sel, 4'h1);
      chk(lit[1:0], 2'b10);
    end
  endtask
  // Slow clock at 1/3 duty: three slots per frame, boost code 01
  task t_slow;
    begin
      @(posedge clk);
      slow_clk_sel <= 1'b1;
      wr(`LSD_CTRL_ADDR, 8'h54);
      wr(`LSD_CTRL_ADDR, 8'hd4);
      wsel(4'h2);
      wsel(4'h4);
      wsel(4'h1);
      chk(i, 4 * 128);
      wtick;
      wtick;
      chk(i, 4 * 8);
    end
  endtask
  // Every boost code; first tick after a write may be short
  task t_boost;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        // booster only with 1/4 duty here
        wr(`LSD_CTRL_ADDR, {4'h4, j[1:0], 2'h3});
        wtick;
        chk(bias_from_pins_q, 0);
        wtick;
        chk(i, 1 << ((j == 0) ? 13 : 12 - j));
      end
    end
  endtask
  initial begin
    repeat (9) @(posedge clk);
    t_reset;
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_buf;
    t_pix;
    t_stop;
    t_blank;
    t_static;
    t_boost;
    t_slow;
    finish_test;
  end
endmodule // tb_top
